/* File: mic_core_model.sv */
// cpu core stand-in: takes offers when allowed, returns on request
// assumes the bench drives ack_en and ret just after sys_clk edges
module mic_core_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic int_pending,
    input  wire logic ack_en,
    input  wire logic ret,
    output logic      int_ack,
    output logic      int_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic done_q; // return pulse register
    logic done_d; // next return pulse
    // takes only what is offered; a slow core holds ack_en low
    always_comb begin
        int_ack = int_pending & ack_en;
        done_d  = ret;
    end
    // one registered return pulse per ret cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end
    assign int_done = done_q;
endmodule

/* File: mic_irq_chk.sv */
// port-level assertions for the interrupt controller
// assumes it is bound onto mic_multilevel_irq_ctrl, one clock
`include "mic_map.svh"
module mic_irq_chk (
    input logic                      sys_clk,
    input logic                      rst,
    input logic                      nmi_req,
    input logic                      int_pending,
    input logic                      int_ack,
    input logic                      int_done,
    input mic_pkg::mic_redirect_type redirect,
    input logic [3:0]                active
);
    timeunit 1ns;
    timeprecision 1ps;
    import mic_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a taken offer redirects the core next cycle
    ack_load_a: assert property (int_pending && int_ack |=> redirect.pc_load)
        else $error("taken offer gave no redirect");
    // no redirect without a cause; reset vector allowed after release
    load_cause_a: assert property (redirect.pc_load |->
        $past(int_pending && int_ack) || $past(rst) || $past(rst, 2))
        else $error("redirect without taken offer");
    // non-maskable redirect lands on its fixed slot
    nmi_vec_a: assert property (redirect.pc_load && redirect.nmi |->
        redirect.pc_vec[14:0] == 15'h0002 && active[3])
        else $error("nmi vector or state wrong");
    // source vectors sit past the fixed slots, word aligned
    vec_step_a: assert property (redirect.pc_load && !redirect.nmi &&
        redirect.lvl != MIC_LVL_OFF |-> redirect.pc_vec[14:0] >= 15'h0004 &&
        !redirect.pc_vec[0])
        else $error("source vector out of table");
    // active nmi handler blocks every offer
    nmi_block_a: assert property (active[3] |-> !int_pending)
        else $error("offer during nmi handler");
    // high handler blocks all but nmi
    hi_block_a: assert property (active[2] && !nmi_req |-> !int_pending)
        else $error("offer during high handler");
    // high redirect marks the high handler busy
    hi_lvl_a: assert property (redirect.pc_load && !redirect.nmi &&
        redirect.lvl == MIC_LVL_HIGH |-> active[2])
        else $error("high redirect not marked active");
    // medium redirect marks the medium handler busy
    med_lvl_a: assert property (redirect.pc_load && !redirect.nmi &&
        redirect.lvl == MIC_LVL_MED |-> active[1])
        else $error("medium redirect not marked active");
    // return from a lone high handler frees it
    done_clear_a: assert property (int_done && active == 4'h4 && !int_ack
        |=> active == 4'h0)
        else $error("return did not clear handler");
    cover property (redirect.pc_load && redirect.nmi);
    cover property (redirect.pc_load && active == 4'h7);
    cover property (int_done && active[0]);
endmodule

/* File: mic_map.svh */
// address map, field positions, reset values and vector constants
// assumes inclusion by the package, the controller, the checker and the bench
`ifndef MIC_MAP_SVH
`define MIC_MAP_SVH

// source count and widths
`define MIC_NSRC          16
`define MIC_IDX_W         4
`define MIC_VEC_W         16
`define MIC_ADDR_W        12

// register byte offsets
`define MIC_OFS_CTRL      12'h000
`define MIC_OFS_STATUS    12'h004
`define MIC_OFS_LEVEL     12'h008

// control field positions
`define MIC_CTRL_LO_EN    0
`define MIC_CTRL_MED_EN   1
`define MIC_CTRL_HI_EN    2
`define MIC_CTRL_RR_EN    3
`define MIC_CTRL_BOOT     4
`define MIC_CTRL_W        5

// status field positions
`define MIC_ACT_LO        0
`define MIC_ACT_MED       1
`define MIC_ACT_HI        2
`define MIC_ACT_NMI       3
`define MIC_RR_LSB        8

// reset values
`define MIC_CTRL_RST      5'h00
`define MIC_LEVEL_RST     32'h0000_0000
`define MIC_ACT_RST       4'h0

// word addresses of vectors, relative to the selected table base
`define MIC_VEC_RESET     16'h0000
`define MIC_VEC_NMI       16'h0002
`define MIC_VEC_FIRST     16'h0004
`define MIC_VEC_STRIDE    16'h0002
`define MIC_BASE_APP      16'h0000
`define MIC_BASE_BOOT     16'h8000

`endif

/* File: mic_multilevel_irq_ctrl.sv */
// multilevel interrupt controller with apb register slave
// assumes requests and core handshakes come from logic on sys_clk

`include "mic_map.svh"

// What this block does
// - each source picks low, medium or high
// - medium request nests inside low handler
// - high request preempts medium and low handlers
// - same level: lowest vector address wins
// - optional round robin among low requests
// - non-maskable class ignores level enables
// - acknowledge loads program counter with vector
// - request only when source enabled and present
// - each source has its own vector, level
// - vector base selects application or boot area
// - vector is base plus per-source offset
// - reset vector 0x000, oscillator failure 0x002
module mic_multilevel_irq_ctrl (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [`MIC_ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [`MIC_NSRC-1:0]          irq_req,
    input  wire logic                          nmi_req,
    output logic                               int_pending,
    input  wire logic                          int_ack,
    input  wire logic                          int_done,
    output mic_pkg::mic_redirect_type          redirect,
    output logic      [3:0]                    active
);
    import mic_pkg::*;

    // lowest set bit of a request mask, with a found flag
    function automatic logic [`MIC_IDX_W:0] first_set(input logic [`MIC_NSRC-1:0] m);
        logic [`MIC_IDX_W:0] r;
        r = '0;
        // scanning downward leaves the lowest set bit last
        for (int k = `MIC_NSRC - 1; k >= 0; k--) begin
            if (m[k]) begin
                r = {1'b1, k[`MIC_IDX_W-1:0]};
            end
        end
        return r;
    endfunction

    // address decode shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [`MIC_ADDR_W-1:0] a);
        logic [1:0] s;
        // code three stands for an unmapped offset
        s = 2'h3;
        if (a == `MIC_OFS_CTRL) begin
            s = 2'h0;
        end else if (a == `MIC_OFS_STATUS) begin
            s = 2'h1;
        end else if (a == `MIC_OFS_LEVEL) begin
            s = 2'h2;
        end
        return s;
    endfunction

    // per-source level costs two flops each but needs no extra enable
    // state
    mic_state_type              state_q,    state_d;     // boot or run
    mic_ctrl_type               ctrl_q,     ctrl_d;      // enables and table select
    logic [2*`MIC_NSRC-1:0]     level_q,    level_d;     // two bits per source
    logic [3:0]                 act_q,      act_d;       // handler active per level
    logic [`MIC_IDX_W-1:0]      rr_q,       rr_d;        // last low source served
    mic_redirect_type           redir_q,    redir_d;     // program counter load
    logic [31:0]                rdata_q,    rdata_d;     // read data register

    // arbitration wires
    // masks from the generate loop, wr_en, wsel and rsel from the apb process, the rest from the arbitration process below
    logic [`MIC_NSRC-1:0]       mask_lo;                 // eligible low requests
    logic [`MIC_NSRC-1:0]       mask_med;                // eligible medium requests
    logic [`MIC_NSRC-1:0]       mask_hi;                 // eligible high requests
    logic [2*`MIC_NSRC-1:0]     lo_twice;                // doubled for rotation
    logic [`MIC_NSRC-1:0]       lo_rot;                  // low mask after rotation
    logic [`MIC_IDX_W:0]        f_hi, f_med, f_lo, f_rot;
    logic [`MIC_IDX_W-1:0]      rot_sh;                  // rotation amount
    logic [`MIC_IDX_W-1:0]      lo_idx;                  // chosen low source
    logic                       hi_ok, med_ok, lo_ok;    // level not held back
    logic                       nmi_ok;                  // nmi may be taken
    logic [`MIC_VEC_W-1:0]      base;                    // selected table base
    logic [`MIC_VEC_W-1:0]      sel_vec;                 // vector offered
    mic_level_type              sel_lvl;                 // level offered
    logic                       sel_nmi;                 // nmi offered
    logic [`MIC_IDX_W-1:0]      sel_idx;                 // source offered
    logic                       taken;                   // core took the offer
    logic                       wr_en;                   // apb write strobe
    logic [1:0]                 wsel, rsel;              // decoded register

    // per-source eligibility; off level means the source is disabled
    genvar gi;
    generate
        for (gi = 0; gi < `MIC_NSRC; gi++) begin : g_src
            // level picks which mask it joins
            assign mask_lo[gi]  = irq_req[gi] && (level_q[2*gi +: 2] == MIC_LVL_LOW);
            assign mask_med[gi] = irq_req[gi] && (level_q[2*gi +: 2] == MIC_LVL_MED);
            assign mask_hi[gi]  = irq_req[gi] && (level_q[2*gi +: 2] == MIC_LVL_HIGH);
        end
    endgenerate

    // arbitration between levels and within a level
    always_comb begin
        // hold back same or lower level while active
        nmi_ok = nmi_req && !act_q[`MIC_ACT_NMI];
        hi_ok  = ctrl_q.hi_en  && (act_q[`MIC_ACT_NMI:`MIC_ACT_HI] == 2'h0);
        med_ok = ctrl_q.med_en && (act_q[`MIC_ACT_NMI:`MIC_ACT_MED] == 3'h0);
        lo_ok  = ctrl_q.lo_en  && (act_q == 4'h0);

        // each level searched on its own
        // lowest index means lowest vector
        f_hi  = first_set(mask_hi);
        f_med = first_set(mask_med);
        f_lo  = first_set(mask_lo);

        // rotation keeps a busy low source from starving the rest
        // search starts just after last served
        rot_sh   = rr_q + `MIC_IDX_W'(1);
        lo_twice = {mask_lo, mask_lo} >> rot_sh;
        lo_rot   = lo_twice[`MIC_NSRC-1:0];
        f_rot    = first_set(lo_rot);
        lo_idx   = ctrl_q.rr_en ? (f_rot[`MIC_IDX_W-1:0] + rot_sh) : f_lo[`MIC_IDX_W-1:0];

        // the boot area moves the table, never the order
        // table base follows the select bit
        base = ctrl_q.boot_sel ? `MIC_BASE_BOOT : `MIC_BASE_APP;

        // defaults: nothing offered
        sel_nmi     = 1'b0;
        sel_lvl     = MIC_LVL_OFF;
        sel_idx     = '0;
        int_pending = 1'b0;
        if (state_q != MIC_ST_RUN) begin
            // nothing offered until the reset vector is out
            int_pending = 1'b0;
        end else if (nmi_ok) begin
            sel_nmi     = 1'b1;
            sel_lvl     = MIC_LVL_HIGH;
            int_pending = 1'b1;
        end else if (hi_ok && f_hi[`MIC_IDX_W]) begin
            sel_lvl     = MIC_LVL_HIGH;
            sel_idx     = f_hi[`MIC_IDX_W-1:0];
            int_pending = 1'b1;
        end else if (med_ok && f_med[`MIC_IDX_W]) begin
            sel_lvl     = MIC_LVL_MED;
            sel_idx     = f_med[`MIC_IDX_W-1:0];
            int_pending = 1'b1;
        end else if (lo_ok && f_lo[`MIC_IDX_W]) begin
            // low only while no handler at all is active
            sel_lvl     = MIC_LVL_LOW;
            sel_idx     = lo_idx;
            int_pending = 1'b1;
        end

        // base plus per-source offset, in words
        // every source owns a distinct slot
        // nmi uses the fixed failure vector
        if (sel_nmi) begin
            sel_vec = base + `MIC_VEC_NMI;
        end else begin
            // two words per slot leave room for a jump
            sel_vec = base + `MIC_VEC_FIRST
                    + `MIC_VEC_W'(`MIC_VEC_STRIDE * {12'h000, sel_idx});
        end
        // an acknowledge without an offer is ignored
        taken = int_pending && int_ack;
    end

    // handler bookkeeping and program counter load
    always_comb begin
        // hold by default; pc_load is a one-cycle pulse
        state_d = state_q;
        act_d   = act_q;
        rr_d    = rr_q;
        redir_d = redir_q;
        redir_d.pc_load = 1'b0;
        // completion retires the innermost handler first
        if (int_done) begin
            if (act_q[`MIC_ACT_NMI]) begin
                // nmi handler is always innermost
                act_d[`MIC_ACT_NMI] = 1'b0;
            end else if (act_q[`MIC_ACT_HI]) begin
                // high nests inside medium and low
                act_d[`MIC_ACT_HI] = 1'b0;
            end else if (act_q[`MIC_ACT_MED]) begin
                // medium nests inside low
                act_d[`MIC_ACT_MED] = 1'b0;
            end else begin
                // only low left, or nothing at all
                act_d[`MIC_ACT_LO] = 1'b0;
            end
        end
        unique case (state_q)
            MIC_ST_BOOT: begin
                // first load is the reset vector
                redir_d.pc_load = 1'b1;
                redir_d.pc_vec  = base + `MIC_VEC_RESET;
                redir_d.lvl     = MIC_LVL_OFF;
                redir_d.nmi     = 1'b0;
                state_d         = MIC_ST_RUN;
            end
            MIC_ST_RUN: begin
                if (taken) begin
                    redir_d.pc_load = 1'b1;
                    redir_d.pc_vec  = sel_vec;
                    redir_d.lvl     = sel_lvl;
                    redir_d.nmi     = sel_nmi;
                    // set after clear, so a new handler is never lost
                    if (sel_nmi) begin
                        act_d[`MIC_ACT_NMI] = 1'b1;
                    end else begin
                        // level code minus one picks its active bit
                        act_d[32'(sel_lvl) - 1] = 1'b1;
                    end
                    if (!sel_nmi && sel_lvl == MIC_LVL_LOW) begin
                        rr_d = sel_idx;
                    end
                end
            end
            default: begin
                // an illegal code restarts from the reset vector
                state_d = MIC_ST_BOOT;
            end
        endcase
    end

    // apb slave; zero wait states, unmapped accesses or writes to status flag an error
    always_comb begin
        // decode once, shared by both paths
        wsel    = reg_sel(paddr);
        rsel    = wsel;
        // never stalls, so no wait state is ever inserted
        pready  = 1'b1;
        // status is read-only, so a write there is refused
        pslverr = psel && penable && ((wsel == 2'h3) || (pwrite && wsel == 2'h1));
        wr_en   = psel && penable && pwrite && !pslverr;
        // registers hold unless written
        ctrl_d  = ctrl_q;
        level_d = level_q;
        rdata_d = rdata_q;
        if (wr_en && wsel == 2'h0) begin
            // only the control bits are kept
            ctrl_d = pwdata[`MIC_CTRL_W-1:0];
        end
        if (wr_en && wsel == 2'h2) begin
            level_d = pwdata;
        end
        // read data captured in setup so it sits in a flop during access
        if (psel && !penable) begin
            // unmapped offsets read as zero
            unique case (rsel)
                2'h0: rdata_d = {27'h000_0000, ctrl_q};
                2'h1: rdata_d = {20'h0_0000, rr_q, 4'h0, act_q};
                2'h2: rdata_d = level_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // registers; reset vector goes out right after reset release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // constants only, so release is clean
            state_q <= MIC_ST_BOOT;
            ctrl_q  <= `MIC_CTRL_RST;
            level_q <= `MIC_LEVEL_RST;
            act_q   <= `MIC_ACT_RST;
            rr_q    <= '0;
            redir_q <= '0;
            rdata_q <= 32'h0000_0000;
        end else begin
            // every register advances on each edge
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            level_q <= level_d;
            act_q   <= act_d;
            rr_q    <= rr_d;
            redir_q <= redir_d;
            rdata_q <= rdata_d;
        end
    end

    // pready and pslverr stay combinational handshakes
    // outputs straight from flops
    assign redirect = redir_q;
    assign active   = act_q;
    assign prdata   = rdata_q;

endmodule

/* File: mic_pkg.sv */
// types shared by the interrupt controller and its bench
// assumes mic_map.svh is on the include path
`include "mic_map.svh"

package mic_pkg;

    // per-source level; off doubles as the per-source enable
    typedef enum logic [1:0] {
        MIC_LVL_OFF  = 2'h0,
        MIC_LVL_LOW  = 2'h1,
        MIC_LVL_MED  = 2'h2,
        MIC_LVL_HIGH = 2'h3
    } mic_level_type;

    // boot emits the reset vector once, run arbitrates
    typedef enum logic [1:0] {
        MIC_ST_BOOT = 2'b00,
        MIC_ST_RUN  = 2'b01
    } mic_state_type;

    // redirect of the core program counter
    typedef struct packed {
        logic                    pc_load;
        logic [`MIC_VEC_W-1:0]   pc_vec;
        mic_level_type           lvl;
        logic                    nmi;
    } mic_redirect_type;

    // software control bits
    typedef struct packed {
        logic boot_sel;
        logic rr_en;
        logic hi_en;
        logic med_en;
        logic lo_en;
    } mic_ctrl_type;

endpackage

/* File: test_mic_multilevel_irq_ctrl.sv */
// self-checking bench: apb register traffic plus core handshakes
// assumes mic_core_model as the core, bench as the peripherals
`include "mic_map.svh"
module test_mic_multilevel_irq_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import mic_pkg::*;
    logic             sys_clk, rst, psel, penable, pwrite, nmi_req, ack_en, ret, e;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, r;
    logic [15:0]      irq_req;
    logic             pready, pslverr, int_pending, int_ack, int_done;
    mic_redirect_type redirect;
    logic [3:0]       active;
    int               failures, total_checks, cyc;
    mic_multilevel_irq_ctrl uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq_req, .nmi_req, .int_pending,
        .int_ack, .int_done, .redirect, .active);
    mic_core_model core (.sys_clk, .rst, .int_pending, .ack_en, .ret, .int_ack,
        .int_done);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task conclude;
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; result left in r and e
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // let the core take one offer and compare the redirect
    task take(input logic [15:0] v, input logic n);
        int i;
        @(posedge sys_clk) ack_en <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (redirect.pc_load === 1'b1) break;
        end
        ack_en <= 1'b0;
        check({31'h0, redirect.pc_load}, 1);
        check({15'h0000, redirect.nmi, redirect.pc_vec}, {15'h0000, n, v});
    endtask
    // peripherals drop served requests, core returns
    task back(input logic [15:0] m);
        @(posedge sys_clk);
        irq_req <= irq_req & ~m;
        ret <= 1'b1;
        @(posedge sys_clk) ret <= 1'b0;
    endtask
    // hang guard, far above the expected run length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            conclude;
        end
    end
    initial begin
        {psel, penable, pwrite, nmi_req, ack_en, ret} = '0;
        {paddr, pwdata, irq_req} = '0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, `MIC_OFS_CTRL, 0); check(r, 0);
        apb(0, `MIC_OFS_LEVEL, 0); check(r, 0);
        apb(1, `MIC_OFS_LEVEL, 32'hFFFF_FFFF);
        apb(0, `MIC_OFS_LEVEL, 0); check(r, 32'hFFFF_FFFF);
        apb(0, 12'h00C, 0); check({31'h0, e}, 1);
        apb(1, `MIC_OFS_STATUS, 0); check({31'h0, e}, 1);
        // disabled source stays silent, then serves as low
        apb(1, `MIC_OFS_LEVEL, 0);
        apb(1, `MIC_OFS_CTRL, 32'h0000_0007);
        irq_req <= 16'h0040;
        repeat (4) @(posedge sys_clk);
        check({31'h0, int_pending}, 0);
        apb(1, `MIC_OFS_LEVEL, 32'h0000_1000);
        take(16'h0010, 0);
        check({30'h0, redirect.lvl}, MIC_LVL_LOW);
        apb(0, `MIC_OFS_STATUS, 0); check(r & 32'h0000_000F, 1);
        back(16'h0040);
        // two high sources: lower vector first
        apb(1, `MIC_OFS_LEVEL, 32'h0000_0CC0);
        irq_req <= 16'h0028;
        take(16'h000A, 0);
        back(16'h0008);
        take(16'h000E, 0);
        back(16'h0020);
        // low, then medium nests, then high preempts
        apb(1, `MIC_OFS_LEVEL, 32'h0000_0324);
        irq_req <= 16'h0002;
        take(16'h0006, 0);
        irq_req <= 16'h0006;
        take(16'h0008, 0);
        check({30'h0, redirect.lvl}, MIC_LVL_MED);
        irq_req <= 16'h0016;
        take(16'h000C, 0);
        check({30'h0, redirect.lvl}, MIC_LVL_HIGH);
        check({28'h0, active}, 32'h7);
        back(16'h0010);
        back(16'h0004);
        back(16'h0002);
        repeat (2) @(posedge sys_clk);
        check({28'h0, active}, 0);
        // non-maskable with every level disabled
        apb(1, `MIC_OFS_CTRL, 0);
        nmi_req <= 1'b1;
        take(16'h0002, 1);
        nmi_req <= 1'b0;
        back(0);
        // boot area table base
        apb(1, `MIC_OFS_CTRL, 32'h0000_0017);
        apb(1, `MIC_OFS_LEVEL, 32'h0000_0004);
        irq_req <= 16'h0002;
        take(16'h8006, 0);
        back(0);
        // round robin among two held low sources
        apb(1, `MIC_OFS_CTRL, 32'h0000_000F);
        apb(1, `MIC_OFS_LEVEL, 32'h0000_0005);
        take(16'h0006, 0);
        back(0);
        irq_req <= 16'h0003;
        take(16'h0004, 0);
        back(0);
        take(16'h0006, 0);
        back(16'h0003);
        conclude;
    end
endmodule
bind mic_multilevel_irq_ctrl mic_irq_chk chk (.sys_clk, .rst, .nmi_req,
    .int_pending, .int_ack, .int_done, .redirect, .active);
